// ### testbench/mtx_ctrl_model.sv
`timescale 1ns/1ps
module mtx_ctrl_model
   import mtx_lane_pkg::*;
(
   // Frame request and next word
   input wire logic go,
   input wire logic [WORD_W-1:0] next_word,
   // Lane clocks and word bus
   output logic par_clk,
   output logic ser_clk,
   output logic [WORD_W-1:0] word
);
   // Clocks stand still between frames; an idle word bus keeps toggling
   initial begin
      par_clk = 1'b0;
      ser_clk = 1'b0;
      word = 8'h00;
      forever begin
         if (go) begin
            word = next_word;
            for (int k = 0; k < WORD_W; k++) begin
               #40 ser_clk = 1'b1;
               par_clk = k < 4;
               #80 ser_clk = 1'b0;
               #40;
            end
         end else begin
            word = ~word;
            #80;
         end
      end
   end
endmodule : mtx_ctrl_model

// ### testbench/mtx_lane_monitor.sv
`timescale 1ns/1ps
module mtx_lane_monitor
   import mtx_lane_pkg::*;
#(
   parameter int SER_HALF = SER_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Controller inputs
   input wire logic hs_drive_enable,
   input wire logic lowpower_pos_drive_en,
   input wire logic lowpower_pos_tx_bit,
   input wire logic lowpower_neg_drive_en,
   input wire logic lowpower_neg_tx_bit,
   // Lane outputs and pads
   input wire logic lowpower_pos_rx_bit,
   input wire logic lowpower_neg_rx_bit,
   input wire logic gen_serial_bit_clock,
   input wire logic gen_parallel_word_clock,
   input wire logic pad_p_i,
   input wire logic pad_p_o,
   input wire logic pad_p_oe_b,
   input wire logic pad_n_i,
   input wire logic pad_n_o,
   input wire logic pad_n_oe_b
);
   // Generated word clock stays high for four serial periods
   localparam int PAR_HIGH = 8 * SER_HALF;
   logic [2:0] age_r;
   wire hs = hs_drive_enable;
   wire ok = age_r == 3'h7;
   // Sync stages hold reset values for a few edges after release
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         age_r <= 3'h0;
      else if (!ok)
         age_r <= age_r + 3'h1;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   property p_hs;
      ok && $past(hs, 3) |-> !pad_p_oe_b && !pad_n_oe_b && pad_n_o != pad_p_o;
   endproperty
   a_hs: assert property (p_hs) else $error("hs pads wrong");
   property p_poff;
      ok && $past(!hs && !lowpower_pos_drive_en, 3) |-> pad_p_oe_b && !pad_p_o;
   endproperty
   a_poff: assert property (p_poff) else $error("p pad not released");
   property p_noff;
      ok && $past(!hs && !lowpower_neg_drive_en, 3) |-> pad_n_oe_b && !pad_n_o;
   endproperty
   a_noff: assert property (p_noff) else $error("n pad not released");
   property p_plp;
      ok && $past(!hs && lowpower_pos_drive_en, 3) |-> !pad_p_oe_b && pad_p_o == $past(lowpower_pos_tx_bit, 3);
   endproperty
   a_plp: assert property (p_plp) else $error("p low power wrong");
   property p_nlp;
      ok && $past(!hs && lowpower_neg_drive_en, 3) |-> !pad_n_oe_b && pad_n_o == $past(lowpower_neg_tx_bit, 3);
   endproperty
   a_nlp: assert property (p_nlp) else $error("n low power wrong");
   property p_prx;
      ok |-> lowpower_pos_rx_bit == $past(pad_p_i, 3);
   endproperty
   a_prx: assert property (p_prx) else $error("p readback wrong");
   property p_nrx;
      ok |-> lowpower_neg_rx_bit == $past(pad_n_i, 3);
   endproperty
   a_nrx: assert property (p_nrx) else $error("n readback wrong");
   property p_ser;
      $rose(gen_serial_bit_clock) |-> ##SER_HALF $fell(gen_serial_bit_clock);
   endproperty
   a_ser: assert property (p_ser) else $error("serial half period wrong");
   property p_par_align;
      $rose(gen_parallel_word_clock) |-> $rose(gen_serial_bit_clock);
   endproperty
   a_par_align: assert property (p_par_align) else $error("word clock not on bit clock edge");
   property p_par_high;
      $rose(gen_parallel_word_clock) |-> ##PAR_HIGH $fell(gen_parallel_word_clock);
   endproperty
   a_par_high: assert property (p_par_high) else $error("word clock high time wrong");
endmodule : mtx_lane_monitor
bind mtx_lane mtx_lane_monitor #(.SER_HALF(SER_HALF)) u_mon (.clk(clk), .rst_b(rst_b),
   .hs_drive_enable(hs_drive_enable), .lowpower_pos_drive_en(lowpower_pos_drive_en),
   .lowpower_pos_tx_bit(lowpower_pos_tx_bit), .lowpower_neg_drive_en(lowpower_neg_drive_en),
   .lowpower_neg_tx_bit(lowpower_neg_tx_bit), .lowpower_pos_rx_bit(lowpower_pos_rx_bit),
   .lowpower_neg_rx_bit(lowpower_neg_rx_bit), .gen_serial_bit_clock(gen_serial_bit_clock),
   .gen_parallel_word_clock(gen_parallel_word_clock), .pad_p_i(pad_p_i), .pad_p_o(pad_p_o),
   .pad_p_oe_b(pad_p_oe_b), .pad_n_i(pad_n_i), .pad_n_o(pad_n_o), .pad_n_oe_b(pad_n_oe_b));

// ### testbench/mtx_lane_tb.sv
`timescale 1ns/1ps
module mtx_lane_tb
   import mtx_lane_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic go = 1'b0;
   logic hs = 1'b0;
   logic uic = 1'b0;
   logic srst = 1'b0;
   int mark = 0;
   logic [1:0] pad_i = 2'h0;
   mtx_lp_ctrl_t lp = '0;
   logic [WORD_W-1:0] nw = 8'h00;
   wire par, ser, ppo, poe, pno, noe, prx, nrx;
   wire gpar, gser;
   // Word and bit clocks that the lane follows in the current source mode
   wire wclk = uic ? gpar : par;
   wire bclk = uic ? gser : ser;
   wire [WORD_W-1:0] w;
   int fails = 0;
   int check_count = 0;
   logic q[$];
   mtx_ctrl_model u_ctrl (.go(go), .next_word(nw), .par_clk(par), .ser_clk(ser), .word(w));
   mtx_lane dut (.clk(clk), .rst_b(rst_b), .parallel_word_clock(par), .serial_bit_clock(ser),
      .use_internal_clocks(uic), .gen_parallel_word_clock(gpar), .gen_serial_bit_clock(gser), .hs_tx_word(w),
      .hs_drive_enable(hs), .serializer_reset(srst), .lowpower_pos_drive_en(lp.pos_en),
      .lowpower_pos_tx_bit(lp.pos_bit), .lowpower_neg_drive_en(lp.neg_en), .lowpower_neg_tx_bit(lp.neg_bit),
      .lowpower_pos_rx_bit(prx), .lowpower_neg_rx_bit(nrx), .pad_p_i(pad_i[1]), .pad_p_o(ppo),
      .pad_p_oe_b(poe), .pad_n_i(pad_i[0]), .pad_n_o(pno), .pad_n_oe_b(noe));
   task automatic chk(string n, logic [3:0] e, logic [3:0] s);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   initial forever #4 clk = ~clk;
   // Cycle ceiling well above the planned run
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      close_out();
   end
   // note bits LSB first; a word taken under reset leaves the line low
   always @(posedge wclk)
      if (hs)
         for (int k = 0; k < WORD_W; k++)
            q.push_back(w[k] & ~srst);
   // Mid-bit look at the pads against the oldest note
   always @(posedge bclk) begin : watch
      logic b;
      #80;
      if (q.size() > 0) begin
         b = q.pop_front();
         chk("hs pads", {1'b0, b, 1'b0, ~b}, {1'b0, ppo, poe, pno});
      end
   end
   initial begin
      void'($urandom(1));
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("reset pads", 4'h6, {1'b0, poe, noe, ppo});
      // Every enable and value pairing, random pad levels
      for (int i = 0; i < 16; i++) begin
         lp = mtx_lp_ctrl_t'(i[3:0]);
         pad_i = 2'($urandom);
         repeat (5) @(posedge clk);
         #1;
         chk("lp pads", {~lp.pos_en, lp.pos_en & lp.pos_bit, ~lp.neg_en, lp.neg_en & lp.neg_bit},
            {poe, ppo, noe, pno});
         chk("readback", {2'h0, pad_i}, {2'h0, prx, nrx});
      end
      // High speed wins over low power; idle line sits low
      hs = 1'b1;
      lp = mtx_lp_ctrl_t'(4'hf);
      repeat (5) @(posedge clk);
      #1;
      chk("hs idle", 4'h1, {1'b0, ppo, poe, pno});
      for (int i = 0; i < 12; i++) begin
         nw = 8'($urandom);
         go = 1'b1;
         @(posedge par);
      end
      go = 1'b0;
      repeat (300) @(posedge clk);
      #1;
      // reset seen at a word edge drops that word
      srst = 1'b1;
      nw = 8'($urandom) | 8'h01;
      go = 1'b1;
      @(posedge par);
      go = 1'b0;
      repeat (300) @(posedge clk);
      #1;
      srst = 1'b0;
      chk("bits left", 4'h0, {3'h0, q.size() != 0});
      // generated clocks; a steady word keeps capture free of races
      hs = 1'b0;
      nw = 8'($urandom) | 8'h01;
      go = 1'b1;
      @(posedge par);
      @(posedge clk);
      #1;
      uic = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      hs = 1'b1;
      mark = check_count;
      repeat (1200) @(posedge clk);
      #1;
      chk("internal bits", 4'h1, {3'h0, check_count > mark + 40});
      close_out();
   end
endmodule : mtx_lane_tb

// ### verilog/mtx_lane.sv
`timescale 1ns/1ps
// Behaviour
// - One 8-bit word per parallel clock, captured.
// - Optional reset on parallel clock clears serializer.
// - Drive high-speed pads only while enabled.
// - Positive pad driven low-power when enabled.
// - Negative pad driven low-power when enabled.
// - Positive pad level returned as input.
// - Negative pad level returned as input.
// - Clock generator makes parallel and serial clocks.
module mtx_lane
   import mtx_lane_pkg::*;
#(
   parameter int SER_HALF = SER_HALF_CYC
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Clocks from the lane clock source, sampled here
   input wire logic parallel_word_clock,
   input wire logic serial_bit_clock,
   // Serializer clock source select and generated clocks
   input wire logic use_internal_clocks,
   output logic gen_parallel_word_clock,
   output logic gen_serial_bit_clock,
   // Controller side, high speed
   input wire logic [WORD_W-1:0] hs_tx_word,
   input wire logic hs_drive_enable,
   input wire logic serializer_reset,
   // Controller side, low power
   input wire logic lowpower_pos_drive_en,
   input wire logic lowpower_pos_tx_bit,
   input wire logic lowpower_neg_drive_en,
   input wire logic lowpower_neg_tx_bit,
   output logic lowpower_pos_rx_bit,
   output logic lowpower_neg_rx_bit,
   // Pad P
   input wire logic pad_p_i,
   output logic pad_p_o,
   output logic pad_p_oe_b,
   // Pad N
   input wire logic pad_n_i,
   output logic pad_n_o,
   output logic pad_n_oe_b
);

   // Width of the bundle of outside inputs that cross into clk
   localparam int SYNC_W = WORD_W + 10;

   // The pad logic is built around a byte; other widths are refused
   if (WORD_W != 8) begin : g_word_check
      $error("mtx_lane: parallel word must be 8 bits");
   end
   if (SER_HALF < 1 || SER_HALF > 255) begin : g_div_check
      $error("mtx_lane: SER_HALF must lie in 1..255");
   end

   // Rising edge between two samples
   function automatic logic rise_of(input logic prev, input logic cur);
      rise_of = cur & ~prev;
   endfunction : rise_of

   // Outside inputs, gathered for the two-stage synchroniser
   wire [SYNC_W-1:0] async_in;
   assign async_in = {hs_tx_word, hs_drive_enable, serializer_reset,
                      lowpower_pos_drive_en, lowpower_pos_tx_bit,
                      lowpower_neg_drive_en, lowpower_neg_tx_bit,
                      pad_p_i, pad_n_i, parallel_word_clock, serial_bit_clock};

   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;

   // Two flip-flops on every input in async_in; only sync2_r is read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
      end
   end

   // Synchronised fields
   wire [WORD_W-1:0] word_s;
   wire hs_en_s;
   wire ser_rst_s;
   wire pad_p_s;
   wire pad_n_s;
   wire par_clk_s;
   wire ser_clk_s;
   mtx_lp_ctrl_t lp_s;
   assign word_s = sync2_r[SYNC_W-1 -: WORD_W];
   assign hs_en_s = sync2_r[9];
   assign ser_rst_s = sync2_r[8];
   assign lp_s = mtx_lp_ctrl_t'(sync2_r[7:4]);
   assign pad_p_s = sync2_r[3];
   assign pad_n_s = sync2_r[2];
   assign par_clk_s = sync2_r[1];
   assign ser_clk_s = sync2_r[0];

   // Previous clock samples for edge finding
   logic par_clk_d_r;
   logic ser_clk_d_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         par_clk_d_r <= 1'b0;
         ser_clk_d_r <= 1'b0;
      end else begin
         par_clk_d_r <= par_clk_s;
         ser_clk_d_r <= ser_clk_s;
      end
   end

   // clock generation divider
   // Serial clock toggles every SER_HALF cycles; parallel is high for bits 0..3
   logic [DIV_CNT_W-1:0] div_cnt_r;
   logic [DIV_CNT_W-1:0] div_cnt_nxt;
   logic gen_ser_r;
   logic gen_ser_nxt;
   logic [2:0] gen_phase_r;
   logic [2:0] gen_phase_nxt;
   logic gen_par_r;
   logic gen_par_nxt;
   wire div_wrap;
   wire int_ser_tick;
   wire int_par_tick;
   assign div_wrap = (div_cnt_r == DIV_CNT_W'(SER_HALF - 1));
   assign div_cnt_nxt = div_wrap ? '0 : div_cnt_r + 8'h01;
   assign gen_ser_nxt = div_wrap ? ~gen_ser_r : gen_ser_r;
   // Phase steps on each generated serial rising edge
   assign int_ser_tick = div_wrap & ~gen_ser_r;
   assign gen_phase_nxt = int_ser_tick ? gen_phase_r + 3'h1 : gen_phase_r;
   assign int_par_tick = int_ser_tick & (gen_phase_nxt == 3'h0);
   assign gen_par_nxt = (gen_phase_nxt < 3'h4);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_r <= '0;
         gen_ser_r <= 1'b0;
         gen_phase_r <= 3'h7;
         gen_par_r <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         gen_ser_r <= gen_ser_nxt;
         gen_phase_r <= gen_phase_nxt;
         gen_par_r <= gen_par_nxt;
      end
   end

   // generated clocks sent to clock and data lanes
   assign gen_serial_bit_clock = gen_ser_r;
   assign gen_parallel_word_clock = gen_par_r;

   // Source selection; the strap is caught by a clocked flop, not at reset
   mtx_clk_src_t clk_src_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_src_r <= MTX_CLK_EXTERNAL;
      end else begin
         clk_src_r <= use_internal_clocks ? MTX_CLK_INTERNAL : MTX_CLK_EXTERNAL;
      end
   end

   // Edges that the serializer acts on
   logic par_edge;
   logic ser_edge;
   always_comb begin
      case (clk_src_r)
         MTX_CLK_INTERNAL: begin
            par_edge = int_par_tick;
            ser_edge = int_ser_tick;
         end
         MTX_CLK_EXTERNAL: begin
            par_edge = rise_of(par_clk_d_r, par_clk_s);
            ser_edge = rise_of(ser_clk_d_r, ser_clk_s);
         end
         default: begin
            par_edge = 1'b0;
            ser_edge = 1'b0;
         end
      endcase
   end

   // Serializer state
   logic [WORD_W-1:0] shift_r;
   logic [WORD_W-1:0] shift_nxt;
   logic [BIT_CNT_W-1:0] bit_cnt_r;
   logic [BIT_CNT_W-1:0] bit_cnt_nxt;
   logic hs_bit_r;
   logic hs_bit_nxt;
   wire lane_reset;
   wire [WORD_W-1:0] src_word;
   wire [BIT_CNT_W-1:0] src_cnt;
   wire bits_left;

   // reset sampled on parallel edge
   // Reset only acts on a parallel clock edge, as it belongs to that domain
   assign lane_reset = par_edge & ser_rst_s;

   // word capture on parallel edge
   // A word edge restarts the bit count even if the old word was not finished
   assign src_word = par_edge ? word_s : shift_r;
   assign src_cnt = par_edge ? '0 : bit_cnt_r;
   assign bits_left = (src_cnt < BIT_CNT_W'(WORD_W));

   always_comb begin
      shift_nxt = src_word;
      bit_cnt_nxt = src_cnt;
      hs_bit_nxt = hs_bit_r;
      if (lane_reset) begin
         shift_nxt = SHIFT_RST;
         bit_cnt_nxt = BIT_CNT_RST;
         hs_bit_nxt = HS_BIT_RST;
      end else if (ser_edge && bits_left) begin
         hs_bit_nxt = src_word[0];
         shift_nxt = {1'b0, src_word[WORD_W-1:1]};
         bit_cnt_nxt = src_cnt + 4'h1;
      end else if (ser_edge) begin
         // Word used up and no new one: line rests low
         hs_bit_nxt = HS_BIT_RST;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_r <= SHIFT_RST;
         bit_cnt_r <= BIT_CNT_RST;
         hs_bit_r <= HS_BIT_RST;
      end else begin
         shift_r <= shift_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         hs_bit_r <= hs_bit_nxt;
      end
   end

   // Pad drive selection; high speed takes priority over low power
   mtx_pad_t pad_nxt;
   mtx_pad_t pad_r;
   always_comb begin
      pad_nxt = PAD_RST;
      if (hs_en_s) begin
         pad_nxt.p_o = hs_bit_nxt;
         pad_nxt.n_o = ~hs_bit_nxt;
         pad_nxt.p_oe_b = 1'b0;
         pad_nxt.n_oe_b = 1'b0;
      end else begin
         pad_nxt.p_o = lp_s.pos_en & lp_s.pos_bit;
         pad_nxt.p_oe_b = ~lp_s.pos_en;
         pad_nxt.n_o = lp_s.neg_en & lp_s.neg_bit;
         pad_nxt.n_oe_b = ~lp_s.neg_en;
      end
   end

   // Pad and readback flops
   logic lp_pos_rx_r;
   logic lp_neg_rx_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pad_r <= PAD_RST;
         lp_pos_rx_r <= 1'b0;
         lp_neg_rx_r <= 1'b0;
      end else begin
         pad_r <= pad_nxt;
         lp_pos_rx_r <= pad_p_s;
         lp_neg_rx_r <= pad_n_s;
      end
   end

   // Outputs
   assign pad_p_o = pad_r.p_o;
   assign pad_p_oe_b = pad_r.p_oe_b;
   assign pad_n_o = pad_r.n_o;
   assign pad_n_oe_b = pad_r.n_oe_b;
   assign lowpower_pos_rx_bit = lp_pos_rx_r;
   assign lowpower_neg_rx_bit = lp_neg_rx_r;

endmodule : mtx_lane

// ### verilog/mtx_lane_pkg.sv
package mtx_lane_pkg;

   // Lane word geometry
   localparam int WORD_W = 8;
   localparam int BIT_CNT_W = 4;

   // Clock figures, both in picoseconds
   localparam int CLK_PERIOD_PS = 8000;
   localparam int SER_PERIOD_PS = 160000;
   // Half of a generated serial period in system clocks, rounded down, never below one
   localparam int SER_HALF_RAW = SER_PERIOD_PS / (2 * CLK_PERIOD_PS);
   localparam int SER_HALF_CYC = (SER_HALF_RAW < 1) ? 1 : SER_HALF_RAW;
   localparam int DIV_CNT_W = 8;

   // Values after reset
   localparam logic [WORD_W-1:0] SHIFT_RST = 8'h00;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h8;
   localparam logic HS_BIT_RST = 1'b0;
   localparam logic PAD_OE_B_RST = 1'b1;

   // Low-power controls of both pads, as the controller gives them
   typedef struct packed {
      logic pos_en;
      logic pos_bit;
      logic neg_en;
      logic neg_bit;
   } mtx_lp_ctrl_t;

   // Pad drive: value and active-low enable for P and N
   typedef struct packed {
      logic p_o;
      logic p_oe_b;
      logic n_o;
      logic n_oe_b;
   } mtx_pad_t;

   // Where the serializer takes its clock edges from
   typedef enum logic {
      MTX_CLK_EXTERNAL,
      MTX_CLK_INTERNAL
   } mtx_clk_src_t;

   localparam mtx_pad_t PAD_RST = '{p_o: 1'b0, p_oe_b: PAD_OE_B_RST, n_o: 1'b0, n_oe_b: PAD_OE_B_RST};

endpackage : mtx_lane_pkg
